// [logic/tla_regs.svh]
/*
  Command-byte offsets, field positions, reset values and the hysteresis ceiling
  of the thermal limit alarm block.
  Assumes it is included by bare name and that readings and limits are whole degrees.
*/
`ifndef TLA_REGS_SVH
`define TLA_REGS_SVH

// Command bytes
`define TLA_CMD_COMMON      8'h02
`define TLA_CMD_STAT_A      8'h08
`define TLA_CMD_STAT_B      8'h09
`define TLA_CMD_STAT_C      8'h0A
`define TLA_CMD_MASK_A      8'h0C
`define TLA_CMD_MASK_B      8'h0D
`define TLA_CMD_MASK_C      8'h0E
`define TLA_CMD_LIM_LOCAL   8'h40
`define TLA_CMD_LIM_RA_A    8'h41
`define TLA_CMD_LIM_RB_A    8'h42
`define TLA_CMD_LIM_RA_B    8'h49
`define TLA_CMD_LIM_RB_B    8'h4A
`define TLA_CMD_HYST        8'h4B

// Field positions inside status and mask registers
`define TLA_BIT_LOCAL       0
`define TLA_BIT_REMOTE_A    1
`define TLA_BIT_REMOTE_B    2
// Summary flag positions in the common status register
`define TLA_BIT_SUM_A       1
`define TLA_BIT_SUM_B       2
`define TLA_BIT_SUM_C       3

// Reset values
`define TLA_RST_MASK_A      3'h1
`define TLA_RST_MASK_B      3'h0
`define TLA_RST_MASK_C      3'h7
`define TLA_RST_LIM_LOCAL   8'h55
`define TLA_RST_LIM_REM_A   8'h6E
`define TLA_RST_LIM_REM_B   8'h55
`define TLA_RST_HYST        8'h0A

// Largest hysteresis in degrees
`define TLA_HYST_MAX        8'h20

`endif

// [logic/tla_pkg.sv]
/*
  Types shared by the thermal limit alarm block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tla_pkg;
  typedef logic [7:0] tla_byte_type;   // One register or reading byte
  typedef logic [2:0] tla_chan_type;   // One bit per channel: remote b, remote a, local
endpackage

// [logic/tla_trip_cell.sv]
/*
  One channel/output trip flag with hysteresis: sets at or above the limit,
  clears below limit minus hysteresis, holds in between.
  Assumes update is a one-cycle pulse at the end of a conversion.
*/
module tla_trip_cell
  import tla_pkg::*;
(
  input  wire logic         clk,      // Core clock
  input  wire logic         rst_b,    // Async reset, active low
  input  wire logic         update,   // Conversion finished pulse
  input  wire tla_byte_type reading,  // Channel reading, degrees
  input  wire tla_byte_type limit,    // Trip limit, degrees
  input  wire tla_byte_type hyst,     // Common hysteresis, degrees
  output logic              over      // Trip flag
);

  logic [8:0] reading_plus;           // Reading plus hysteresis, no wrap

  // Compare reading+hyst against limit so a limit below hysteresis never wraps
  assign reading_plus = {1'b0, reading} + {1'b0, hyst};

  // Flag update at each conversion end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      over <= 1'b0;
    end else if (update) begin
      if (reading >= limit) begin
        over <= 1'b1;                                    // see RQ7 see RQ8
      end else if (reading_plus < {1'b0, limit}) begin
        over <= 1'b0;                                    // see RQ9
      end
    end
  end

endmodule // tla_trip_cell

// [logic/tla_alarm.sv]
/*
  Over-temperature alarm logic: three channels against one local limit and two remote limit sets with
  shared hysteresis, three status registers, three masks, three active-low
  critical outputs and a command-byte register port.
  Assumes the serial bus front end presents decoded command-byte accesses as
  single-cycle strobes, and the conversion engine pulses conv_done with readings.
*/
// Notes on behaviour
// RQ1: Output a asserts on any unmasked status bit.
// RQ2: Output a releases once its status clears.
// RQ3: Output b asserts on any unmasked status bit.
// RQ4: Output b releases once its status clears.
// RQ5: Output c asserts on any unmasked status bit.
// RQ6: Output c releases once its status clears.
// RQ7: Remote bits set at reading >= output-a limit.
// RQ8: Local bit set at reading >= local limit.
// RQ9: Clear below limit minus hysteresis, else hold.
// RQ10: Output b uses remote second limits.
// RQ11: Output c reuses remote second limits.
// RQ12: Bits 7..3 of status, mask read zero.
// RQ13: Mask 1 blocks channel, 0 passes it.
// RQ14: Output-a mask resets to 0x01.
// RQ15: Common status shows per-register summary flags.
// RQ16: Hysteresis 0..32 applies to all limits.
// RQ17: Outputs b, c own three-bit masks.
// RQ18: Outputs active low; status updates per conversion.
`include "tla_regs.svh"

module tla_alarm
  import tla_pkg::*;
(
  input  wire logic         clk,                 // Core clock, 40 MHz
  input  wire logic         rst_b,               // Async reset, active low
  input  wire logic         conv_done,           // Conversion finished pulse
  input  wire tla_byte_type local_temp,          // Local reading, degrees
  input  wire tla_byte_type remote_a_temp,       // Remote channel 1 reading
  input  wire tla_byte_type remote_b_temp,       // Remote channel 2 reading
  input  wire tla_byte_type cmd_addr,            // Command byte
  input  wire logic         cmd_wr,              // Write strobe
  input  wire logic         cmd_rd,              // Read strobe
  input  wire tla_byte_type cmd_wdata,           // Write data
  output tla_byte_type      cmd_rdata,           // Read data, one cycle after cmd_rd
  output logic              crit_alarm_out_a_b,  // First critical output, low active
  output logic              crit_alarm_out_b_b,  // Second critical output, low active
  output logic              crit_alarm_out_c_b   // Third critical output, low active
);

  tla_chan_type first_alarm_status;              // local_over_a, remote_a/b_over_a
  tla_chan_type second_alarm_status;             // local_over_b, remote_a/b_over_b
  tla_chan_type third_alarm_status;              // local_over_c, remote_a/b_over_c
  tla_chan_type first_alarm_mask;                // local_block, remote_a/b_block_a
  tla_chan_type second_alarm_mask;               // Mask for output b
  tla_chan_type third_alarm_mask;                // Mask for output c
  tla_byte_type lim_local;                       // Local limit, bit 7 reads zero
  tla_byte_type lim_rem_a_first;                 // Remote 1 limit for output a
  tla_byte_type lim_rem_b_first;                 // Remote 2 limit for output a
  tla_byte_type lim_rem_a_second;                // Remote 1 limit for outputs b, c
  tla_byte_type lim_rem_b_second;                // Remote 2 limit for outputs b, c
  tla_byte_type hyst;                            // Common hysteresis
  tla_chan_type over_flags [3];                  // Trip flags per output
  tla_byte_type readings [3];                    // Readings by channel bit

  assign readings[`TLA_BIT_LOCAL]    = local_temp;
  assign readings[`TLA_BIT_REMOTE_A] = remote_a_temp;
  assign readings[`TLA_BIT_REMOTE_B] = remote_b_temp;
  assign first_alarm_status  = over_flags[0];
  assign second_alarm_status = over_flags[1];
  assign third_alarm_status  = over_flags[2];

  // Gate status with mask; a set mask bit blocks that channel
  function automatic logic alarm_on(input tla_chan_type stat, input tla_chan_type mask);
    alarm_on = |(stat & ~mask);                  // see RQ13
  endfunction

  // Trip cells: one per output and channel
  genvar o, c;
  generate
    for (o = 0; o < 3; o++) begin : g_out
      for (c = 0; c < 3; c++) begin : g_chan
        tla_byte_type limit_sel;                 // Limit chosen for this pair
        if (c == `TLA_BIT_LOCAL) begin : g_loc
          assign limit_sel = lim_local;          // see RQ8
        end else if (o == 0) begin : g_first
          assign limit_sel = (c == `TLA_BIT_REMOTE_A) ? lim_rem_a_first
                                                      : lim_rem_b_first;  // see RQ7
        end else begin : g_second
          assign limit_sel = (c == `TLA_BIT_REMOTE_A) ? lim_rem_a_second
                                                      : lim_rem_b_second; // see RQ10 see RQ11
        end
        tla_trip_cell u_cell (
          .clk     (clk),
          .rst_b   (rst_b),
          .update  (conv_done),                  // see RQ18
          .reading (readings[c]),
          .limit   (limit_sel),
          .hyst    (hyst),                       // see RQ16
          .over    (over_flags[o][c])
        );
      end
    end
  endgenerate

  // Mask registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_alarm_mask  <= `TLA_RST_MASK_A;      // see RQ14
      second_alarm_mask <= `TLA_RST_MASK_B;
      third_alarm_mask  <= `TLA_RST_MASK_C;
    end else if (cmd_wr) begin
      if (cmd_addr == `TLA_CMD_MASK_A) begin
        first_alarm_mask <= cmd_wdata[2:0];      // see RQ13
      end
      if (cmd_addr == `TLA_CMD_MASK_B) begin
        second_alarm_mask <= cmd_wdata[2:0];     // see RQ17
      end
      if (cmd_addr == `TLA_CMD_MASK_C) begin
        third_alarm_mask <= cmd_wdata[2:0];      // see RQ17
      end
    end
  end

  // Limit and hysteresis registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lim_local        <= `TLA_RST_LIM_LOCAL;
      lim_rem_a_first  <= `TLA_RST_LIM_REM_A;
      lim_rem_b_first  <= `TLA_RST_LIM_REM_A;
      lim_rem_a_second <= `TLA_RST_LIM_REM_B;
      lim_rem_b_second <= `TLA_RST_LIM_REM_B;
      hyst             <= `TLA_RST_HYST;
    end else if (cmd_wr) begin
      unique case (cmd_addr)
        `TLA_CMD_LIM_LOCAL: begin
          lim_local <= {1'b0, cmd_wdata[6:0]};   // Local range tops at 127
        end
        `TLA_CMD_LIM_RA_A: begin
          lim_rem_a_first <= cmd_wdata;
        end
        `TLA_CMD_LIM_RB_A: begin
          lim_rem_b_first <= cmd_wdata;
        end
        `TLA_CMD_LIM_RA_B: begin
          lim_rem_a_second <= cmd_wdata;
        end
        `TLA_CMD_LIM_RB_B: begin
          lim_rem_b_second <= cmd_wdata;
        end
        `TLA_CMD_HYST: begin
          // Saturate out-of-range writes at the ceiling
          hyst <= (cmd_wdata > `TLA_HYST_MAX) ? `TLA_HYST_MAX : cmd_wdata; // see RQ16
        end
        default: begin
          // Other commands do not touch limits
        end
      endcase
    end
  end

  // Critical outputs, low while any unmasked status bit is set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crit_alarm_out_a_b <= 1'b1;
      crit_alarm_out_b_b <= 1'b1;
      crit_alarm_out_c_b <= 1'b1;
    end else begin
      crit_alarm_out_a_b <= ~alarm_on(first_alarm_status, first_alarm_mask);   // see RQ1 see RQ2
      crit_alarm_out_b_b <= ~alarm_on(second_alarm_status, second_alarm_mask); // see RQ3 see RQ4
      crit_alarm_out_c_b <= ~alarm_on(third_alarm_status, third_alarm_mask);   // see RQ5 see RQ6
    end
  end

  // Read port, registered; unmapped commands read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_rd) begin
      unique case (cmd_addr)
        `TLA_CMD_COMMON:    cmd_rdata <= {4'h0, |third_alarm_status, |second_alarm_status,
                                          |first_alarm_status, 1'b0};     // see RQ15
        `TLA_CMD_STAT_A:    cmd_rdata <= {5'h00, first_alarm_status};     // see RQ12
        `TLA_CMD_STAT_B:    cmd_rdata <= {5'h00, second_alarm_status};    // see RQ12
        `TLA_CMD_STAT_C:    cmd_rdata <= {5'h00, third_alarm_status};     // see RQ12
        `TLA_CMD_MASK_A:    cmd_rdata <= {5'h00, first_alarm_mask};       // see RQ12
        `TLA_CMD_MASK_B:    cmd_rdata <= {5'h00, second_alarm_mask};
        `TLA_CMD_MASK_C:    cmd_rdata <= {5'h00, third_alarm_mask};
        `TLA_CMD_LIM_LOCAL: cmd_rdata <= lim_local;
        `TLA_CMD_LIM_RA_A:  cmd_rdata <= lim_rem_a_first;
        `TLA_CMD_LIM_RB_A:  cmd_rdata <= lim_rem_b_first;
        `TLA_CMD_LIM_RA_B:  cmd_rdata <= lim_rem_a_second;
        `TLA_CMD_LIM_RB_B:  cmd_rdata <= lim_rem_b_second;
        `TLA_CMD_HYST:      cmd_rdata <= hyst;
        default:            cmd_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_status_a;
    cmd_rd && (cmd_addr == `TLA_CMD_STAT_A || cmd_addr == `TLA_CMD_MASK_A);
  endsequence

  sequence s_rd_common;
    cmd_rd && cmd_addr == `TLA_CMD_COMMON;
  endsequence

  a_out_a_set: assert property ( // see RQ1
    (|(first_alarm_status & ~first_alarm_mask)) |=> !crit_alarm_out_a_b)
    else $error("output a not asserted");
  a_out_a_free: assert property ( // see RQ2
    (first_alarm_status == 3'h0) |=> crit_alarm_out_a_b)
    else $error("output a not released");
  a_out_b_set: assert property ( // see RQ3
    (|(second_alarm_status & ~second_alarm_mask)) |=> !crit_alarm_out_b_b)
    else $error("output b not asserted");
  a_out_b_free: assert property ( // see RQ4
    (second_alarm_status == 3'h0) |=> crit_alarm_out_b_b)
    else $error("output b not released");
  a_out_c_set: assert property ( // see RQ5
    (|(third_alarm_status & ~third_alarm_mask)) |=> !crit_alarm_out_c_b)
    else $error("output c not asserted");
  a_out_c_free: assert property ( // see RQ6
    (third_alarm_status == 3'h0) |=> crit_alarm_out_c_b)
    else $error("output c not released");
  a_remote_first: assert property ( // see RQ7
    conv_done && remote_b_temp >= lim_rem_b_first |=> first_alarm_status[2])
    else $error("remote b over a not set");
  a_local_trip: assert property ( // see RQ8
    conv_done && local_temp >= lim_local
      |=> first_alarm_status[0] && second_alarm_status[0] && third_alarm_status[0])
    else $error("local bits not set");
  a_band_hold: assert property ( // see RQ9
    conv_done && remote_a_temp < lim_rem_a_first
      && ({1'b0, remote_a_temp} + {1'b0, hyst}) >= {1'b0, lim_rem_a_first}
      |=> $stable(first_alarm_status[1]))
    else $error("hysteresis band not held");
  a_remote_second: assert property ( // see RQ10
    conv_done && remote_a_temp >= lim_rem_a_second |=> second_alarm_status[1])
    else $error("remote a over b not set");
  a_remote_third: assert property ( // see RQ11
    conv_done && remote_b_temp >= lim_rem_b_second |=> third_alarm_status[2])
    else $error("remote b over c not set");
  a_reserved_zero: assert property ( // see RQ12
    s_rd_status_a |=> cmd_rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");
  a_mask_block: assert property ( // see RQ13
    first_alarm_mask == 3'h7 |=> crit_alarm_out_a_b)
    else $error("fully masked output a asserted");
  a_summary_flag: assert property ( // see RQ15
    s_rd_common |=> cmd_rdata[3:1] == $past({|third_alarm_status, |second_alarm_status,
                                            |first_alarm_status}))
    else $error("summary flags wrong");
  a_hyst_range: assert property ( // see RQ16
    hyst <= `TLA_HYST_MAX)
    else $error("hysteresis out of range");
  a_mask_b_write: assert property ( // see RQ17
    cmd_wr && cmd_addr == `TLA_CMD_MASK_B |=> second_alarm_mask == $past(cmd_wdata[2:0]))
    else $error("mask b not written");

endmodule // tla_alarm

// [bench/tla_shutdown_model.sv]
/*
  Shutdown and fan controller model that watches the three critical outputs.
  Assumes the outputs are active-low levels in the core clock domain.
*/
module tla_shutdown_model
  import tla_pkg::*;
(
  input  wire logic         clk,        // Core clock
  input  wire logic         rst_b,      // Reset, active low
  input  wire logic         alarm_a_b,  // First critical output
  input  wire logic         alarm_b_b,  // Second critical output
  input  wire logic         alarm_c_b,  // Third critical output
  output tla_byte_type      trips,      // Count of first-output assertions
  output logic              fan_on      // Fan request from second or third
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_a;  // Previous level of the first output

  // Count each high-to-low step, so a glitch shows up as an extra trip
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_a <= 1'b1;
      trips  <= 8'h00;
    end else begin
      last_a <= alarm_a_b;
      if (last_a && !alarm_a_b) begin
        trips <= trips + 8'h01;
      end
    end
  end

  // Fans run while either lower-level output is active
  assign fan_on = !alarm_b_b || !alarm_c_b;
endmodule  // tla_shutdown_model

// [bench/testbench.sv]
/*
  Self-checking bench for the thermal limit alarm block.
  Assumes single-cycle command strobes; conv_done pulses are single-cycle except in the consecutive-conversion test, which holds it for three edges.
*/
module testbench;
  import tla_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // One table row: masks, readings, expected status and outputs {a,b,c}
  typedef struct packed {
    tla_chan_type ma, mb, mc;
    tla_byte_type l, ra, rb;
    tla_chan_type sa, sb;
    logic [2:0]   o;
  } tla_row_type;
  logic         clk, rst_b, conv_done, cmd_wr, cmd_rd, oa, ob, oc, fan_on;  // Pins
  tla_byte_type lt, rat, rbt, cmd_addr, cmd_wdata, cmd_rdata, trips, got, t0;  // Bytes
  int           n_fail, n_checks;  // Counters
  tla_row_type  rows [6] = '{
    '{3'h0, 3'h0, 3'h0, 8'h55, 8'h00, 8'h00, 3'h1, 3'h1, 3'h0},
    '{3'h0, 3'h0, 3'h0, 8'h54, 8'h63, 8'h77, 3'h0, 3'h6, 3'h4},
    '{3'h0, 3'h0, 3'h0, 8'h00, 8'h64, 8'h59, 3'h2, 3'h2, 3'h0},
    '{3'h7, 3'h7, 3'h7, 8'hC8, 8'hC8, 8'hC8, 3'h7, 3'h7, 3'h7},
    '{3'h6, 3'h5, 3'h3, 8'h00, 8'h64, 8'h00, 3'h2, 3'h2, 3'h5},
    '{3'h3, 3'h6, 3'h5, 8'h00, 8'h00, 8'h78, 3'h4, 3'h4, 3'h3}};
  // Command byte and value after reset
  tla_byte_type rst_tab [13][2] = '{'{8'h02, 8'h00}, '{8'h08, 8'h00}, '{8'h09, 8'h00},
    '{8'h0A, 8'h00}, '{8'h0C, 8'h01}, '{8'h0D, 8'h00}, '{8'h0E, 8'h07}, '{8'h40, 8'h55},
    '{8'h41, 8'h6E}, '{8'h42, 8'h6E}, '{8'h49, 8'h55}, '{8'h4A, 8'h55}, '{8'h4B, 8'h0A}};

  tla_alarm DUT (.clk(clk), .rst_b(rst_b), .conv_done(conv_done), .local_temp(lt),
    .remote_a_temp(rat), .remote_b_temp(rbt), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .crit_alarm_out_a_b(oa), .crit_alarm_out_b_b(ob), .crit_alarm_out_c_b(oc));
  tla_shutdown_model host (.clk(clk), .rst_b(rst_b), .alarm_a_b(oa), .alarm_b_b(ob),
    .alarm_c_b(oc), .trips(trips), .fan_on(fan_on));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk_reg(input string nm, input tla_byte_type e, input tla_byte_type s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask
  // Write strobe, then one idle edge so the strobe is never set twice in a step
  task automatic wr(input tla_byte_type a, input tla_byte_type d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read and compare; data holds until the next read strobe
  task automatic rchk(input tla_byte_type a, input tla_byte_type e);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    repeat (2) @(posedge clk);
    got = cmd_rdata;
    chk_reg($sformatf("reg_%h", a), e, got);
  endtask
  task automatic conv(input tla_byte_type l, input tla_byte_type r1, input tla_byte_type r2);
    conv_done <= 1'b1;
    lt <= l;
    rat <= r1;
    rbt <= r2;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask
  // Outputs lag status by one more edge
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  task automatic pins(input logic [2:0] e);
    chk_pin("out_a", e[2], oa);
    chk_pin("out_b", e[1], ob);
    chk_pin("out_c", e[0], oc);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected done seen hang");
    results;
  end

  initial begin
    {rst_b, conv_done, cmd_wr, cmd_rd} = 4'h0;
    {lt, rat, rbt, cmd_addr, cmd_wdata} = 40'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    pins(3'h7);
    foreach (rst_tab[i]) rchk(rst_tab[i][0], rst_tab[i][1]);
    // Distinct limits so each output's limit choice shows
    wr(8'h41, 8'h64);
    wr(8'h42, 8'h78);
    wr(8'h49, 8'h50);
    wr(8'h4A, 8'h5A);
    foreach (rows[i]) begin
      conv(8'h00, 8'h00, 8'h00);
      wr(8'h0C, {5'h00, rows[i].ma});
      wr(8'h0D, {5'h00, rows[i].mb});
      wr(8'h0E, {5'h00, rows[i].mc});
      conv(rows[i].l, rows[i].ra, rows[i].rb);
      settle;
      pins(rows[i].o);
      rchk(8'h08, {5'h00, rows[i].sa});
      rchk(8'h09, {5'h00, rows[i].sb});
      rchk(8'h0A, {5'h00, rows[i].sb});
      rchk(8'h02, {4'h0, |rows[i].sb, |rows[i].sb, |rows[i].sa, 1'b0});
    end
    // Hysteresis band edges on the local channel
    wr(8'h0C, 8'h00);
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h4B, 8'h05);
    conv(8'h00, 8'h00, 8'h00);
    settle;
    t0 = trips;
    conv(8'h5A, 8'h00, 8'h00);
    settle;
    pins(3'h0);
    chk_pin("fan_on", 1'b1, fan_on);
    conv(8'h51, 8'h00, 8'h00);
    conv(8'h50, 8'h00, 8'h00);
    settle;
    pins(3'h0);
    rchk(8'h08, 8'h01);
    conv(8'h4F, 8'h00, 8'h00);
    settle;
    pins(3'h7);
    rchk(8'h08, 8'h00);
    chk_reg("trips", t0 + 8'h01, trips);
    // Conversions on consecutive edges: last one wins
    conv_done <= 1'b1;
    lt <= 8'h5A;
    @(posedge clk);
    lt <= 8'h00;
    @(posedge clk);
    rat <= 8'h64;
    @(posedge clk);
    conv_done <= 1'b0;
    settle;
    rchk(8'h08, 8'h02);
    rchk(8'h09, 8'h02);
    wr(8'h08, 8'hFF);
    rchk(8'h08, 8'h02);
    rchk(8'h30, 8'h00);
    // Reset in mid-run with an alarm active
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    pins(3'h7);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(8'h0C, 8'h01);
    rchk(8'h08, 8'h00);
    // Field limits on writable registers
    wr(8'h4B, 8'hFF);
    rchk(8'h4B, 8'h20);
    wr(8'h40, 8'hFF);
    rchk(8'h40, 8'h7F);
    wr(8'h0D, 8'hF8);
    rchk(8'h0D, 8'h00);
    wr(8'h0C, 8'hFF);
    rchk(8'h0C, 8'h07);
    results;
  end
endmodule  // testbench
